// >>> g1_defines.svh
// constants for the group 1 verify/write command decoder
`ifndef G1_DEFINES_SVH
`define G1_DEFINES_SVH

`define G1_OP_VERIFY 8'h2f
`define G1_OP_WRITE_EXT 8'h2a
`define G1_OP_WRITE_VERIFY 8'h2e

`define G1_CDB_LAST 4'h9
`define G1_CDB_LEN 10
`define G1_BYTE_OPC 0
`define G1_BYTE_FLAGS 1
`define G1_BYTE_LBA0 2
`define G1_BYTE_LBA1 3
`define G1_BYTE_LBA2 4
`define G1_BYTE_LBA3 5
`define G1_BYTE_RSVD 6
`define G1_BYTE_CNT_HI 7
`define G1_BYTE_CNT_LO 8
`define G1_BYTE_CTRL 9

`define G1_LUN_HI 7
`define G1_LUN_LO 5
`define G1_BYTE_COMPARE_BIT 1
`define G1_REL_ADDR_BIT 0
`define G1_RETRY_BIT 7
`define G1_ECC_BIT 6
`define G1_FLAG_BIT 1
`define G1_LINK_BIT 0
`define G1_FLAGS_RSVD_MASK 8'h1c
`define G1_CTRL_RSVD_MASK 8'h3c

`define G1_MAX_BLOCKS 16'h0100
`define G1_BLOCK_LEN 16'h0200
`define G1_FIFO_DEPTH 8
`define G1_LUNS 8

`define G1_ST_GOOD 8'h00
`define G1_ST_CHECK 8'h02
`define G1_ST_INTERMEDIATE 8'h10
`define G1_SK_NONE 4'h0
`define G1_SK_ILLEGAL 4'h5

`endif

// >>> g1_pkg.sv
// types shared by the group 1 command decoder
`default_nettype none
package g1_pkg;
  // gray codes along gather -> decode -> exec -> report -> gather
  typedef enum logic [1:0] {
    ST_GATHER = 2'h0,
    ST_DECODE = 2'h1,
    ST_EXEC = 2'h3,
    ST_REPORT = 2'h2
  } state_t;

  typedef enum logic [2:0] {
    OPK_WRITE = 3'h0,
    OPK_VERIFY_ECC = 3'h1,
    OPK_VERIFY_CMP = 3'h2,
    OPK_WRITE_VERIFY_ECC = 3'h3,
    OPK_WRITE_VERIFY_CMP = 3'h4
  } op_kind_t;
endpackage : g1_pkg
`default_nettype wire

// >>> byte_stream_if.sv
// valid/ready byte stream between the decoder and its fifo
`default_nettype none
interface byte_stream_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// >>> data_fifo.sv
// initiator-to-drive data fifo with a registered output stage
`default_nettype none
module data_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  // depth must be a power of two so the pointers wrap on their own
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic out_valid;
  logic [WIDTH-1:0] out_data;
  logic push;
  logic load;

  assign in_s.ready = (count < (AW+1)'(DEPTH));
  assign push = in_s.valid && in_s.ready;
  // refill the output stage when empty or being drained
  assign load = (count != '0) && (!out_valid || out_s.ready);
  assign out_s.valid = out_valid;
  assign out_s.data = out_data;
  assign level_o = count;

  // storage write side
  always_ff @(posedge mclk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_s.data;
  end

  // pointers and occupancy
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + 1'b1;
      if (load)
        rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end

  // output stage, stalls while the drive holds ready low
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (load)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_s.ready)
      out_valid <= 1'b0;
  end
endmodule : data_fifo
`default_nettype wire

// >>> lba_memory.sv
// last accessed logical block per unit within a linked chain
`default_nettype none
module lba_memory #(
  parameter int LUNS = 8
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic wr_en_i,
  input wire logic [$clog2(LUNS)-1:0] wr_lun_i,
  input wire logic [31:0] wr_lba_i,
  input wire logic [$clog2(LUNS)-1:0] rd_lun_i,
  output logic [31:0] rd_lba_o,
  output logic rd_valid_o
);
  logic [31:0] lba_mem [LUNS];
  logic [LUNS-1:0] seen;

  assign rd_lba_o = lba_mem[rd_lun_i];
  assign rd_valid_o = seen[rd_lun_i];

  // block address store
  always_ff @(posedge mclk_i)
  begin
    if (wr_en_i)
      lba_mem[wr_lun_i] <= wr_lba_i;
  end

  // a fresh write in the clearing cycle still counts
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      seen <= '0;
    else
    begin
      if (clear_i)
        seen <= '0;
      if (wr_en_i)
        seen[wr_lun_i] <= 1'b1;
    end
  end
endmodule : lba_memory
`default_nettype wire

// >>> g1_cmd_decoder.sv
// group 1 verify / write extended / write and verify command decoder
`include "g1_defines.svh"
`default_nettype none
// Summary of operation
// - opcode 2f verifies the requested consecutive blocks from the given block.
// - opcode 2a writes initiator data starting at the given block.
// - write data amount is block count times configured block length.
// - opcode 2e writes the blocks, then verifies them.
// - unit number comes from bits 7..5 of command byte 1.
// - byte-compare set: take data as for write, compare with read-back.
// - byte-compare clear: read and check ecc only, no data phase for opcode 2f.
// - relative addressing adds signed block field to unit's last block.
// - relative without earlier access in chain: check condition, illegal request.
// - starting block from bytes 2..5, most significant first.
// - count from bytes 7..8; zero moves nothing, 1..256 move that many.
// - retry and correction bits at byte 9 bits 7 and 6, passed on.
// - flag counts only with link set; then raise an interrupt request.
// - link with success fetches next command; status for every command.
// - with disconnect enabled, bus may be released during execution.
module g1_cmd_decoder #(
  parameter int FIFO_DEPTH = `G1_FIFO_DEPTH,
  parameter int LUNS = `G1_LUNS
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] block_len_i,
  input wire logic disconnect_en_i,
  input wire logic cdb_valid_i,
  input wire logic [7:0] cdb_byte_i,
  output logic cdb_ready_o,
  input wire logic data_valid_i,
  input wire logic [7:0] data_byte_i,
  output logic data_ready_o,
  output logic drv_valid_o,
  output logic [7:0] drv_byte_o,
  input wire logic drv_ready_i,
  output logic op_valid_o,
  output g1_pkg::op_kind_t op_kind_o,
  output logic [2:0] op_lun_o,
  output logic [31:0] op_lba_o,
  output logic [8:0] op_count_o,
  output logic op_retry_o,
  output logic op_ecc_o,
  input wire logic op_done_i,
  input wire logic [3:0] op_sense_i,
  output logic disconnect_o,
  output logic status_valid_o,
  output logic [7:0] status_o,
  output logic [3:0] sense_key_o,
  output logic link_next_o,
  output logic flag_irq_o
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  g1_pkg::state_t state;
  logic [7:0] cdb [`G1_CDB_LEN];
  logic [3:0] idx;
  logic [24:0] bytes_left;
  logic in_chain;
  logic cmd_good;
  logic cmd_link;
  logic cmd_flag;
  logic [31:0] end_lba;
  logic push;
  logic [LW-1:0] level;

  // decoded command fields
  logic [7:0] opc;
  logic [2:0] lun;
  logic byte_compare;
  logic relative_addressing;
  logic [31:0] lba_field;
  logic [15:0] count;
  logic known;
  logic rsvd_bad;
  logic rel_bad;
  logic [31:0] start_lba;
  logic [24:0] total;
  logic moves_data;
  logic [31:0] tbl_lba;
  logic tbl_valid;

  byte_stream_if #(.WIDTH(8)) fill_s ();
  byte_stream_if #(.WIDTH(8)) drain_s ();

  // reserved-bit test, write extended also reserves the compare bit
  function automatic logic rsvd_check(input logic [7:0] op, input logic [7:0] b1,
                                      input logic [7:0] b6, input logic [7:0] b9);
    logic [7:0] m1;
    m1 = `G1_FLAGS_RSVD_MASK;
    if (op == `G1_OP_WRITE_EXT)
      m1[`G1_BYTE_COMPARE_BIT] = 1'b1;
    rsvd_check = ((b1 & m1) != 8'h00) || (b6 != 8'h00) ||
                 ((b9 & `G1_CTRL_RSVD_MASK) != 8'h00);
  endfunction : rsvd_check

  assign opc = cdb[`G1_BYTE_OPC];
  assign lun = cdb[`G1_BYTE_FLAGS][`G1_LUN_HI:`G1_LUN_LO];
  assign byte_compare = cdb[`G1_BYTE_FLAGS][`G1_BYTE_COMPARE_BIT] && (opc != `G1_OP_WRITE_EXT);
  assign relative_addressing = cdb[`G1_BYTE_FLAGS][`G1_REL_ADDR_BIT];
  assign lba_field = {cdb[`G1_BYTE_LBA0], cdb[`G1_BYTE_LBA1],
                      cdb[`G1_BYTE_LBA2], cdb[`G1_BYTE_LBA3]};
  assign count = {cdb[`G1_BYTE_CNT_HI], cdb[`G1_BYTE_CNT_LO]};
  assign known = (opc == `G1_OP_VERIFY) || (opc == `G1_OP_WRITE_EXT) ||
                 (opc == `G1_OP_WRITE_VERIFY);
  assign rsvd_bad = rsvd_check(opc, cdb[`G1_BYTE_FLAGS], cdb[`G1_BYTE_RSVD],
                               cdb[`G1_BYTE_CTRL]);
  // relative only inside a linked chain with an earlier access on the unit
  assign rel_bad = relative_addressing && (!in_chain || !tbl_valid);
  assign start_lba = relative_addressing ? tbl_lba + lba_field : lba_field;
  // widen before the product so a long block length cannot wrap
  assign total = 25'(count[8:0]) * 25'(block_len_i);
  // verify without compare has no data phase at all
  assign moves_data = (opc != `G1_OP_VERIFY) || byte_compare;

  assign push = data_valid_i && data_ready_o;
  assign fill_s.valid = push;
  assign fill_s.data = data_byte_i;
  assign drv_valid_o = drain_s.valid;
  assign drv_byte_o = drain_s.data;
  assign drain_s.ready = drv_ready_i;

  data_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_s(fill_s),
    .out_s(drain_s),
    .level_o(level)
  );

  lba_memory #(.LUNS(LUNS)) u_lba (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(state == g1_pkg::ST_REPORT && !(cmd_good && cmd_link)),
    .wr_en_i(state == g1_pkg::ST_EXEC && op_done_i && op_sense_i == `G1_SK_NONE),
    .wr_lun_i(op_lun_o),
    .wr_lba_i(end_lba),
    .rd_lun_i(lun),
    .rd_lba_o(tbl_lba),
    .rd_valid_o(tbl_valid)
  );

  // main sequence and command byte capture
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state <= g1_pkg::ST_GATHER;
      idx <= 4'h0;
      cdb_ready_o <= 1'b1;
    end
    else
    begin
      case (state)
        g1_pkg::ST_GATHER:
        begin
          if (cdb_valid_i && cdb_ready_o)
          begin
            cdb[idx] <= cdb_byte_i;
            idx <= idx + 4'h1;
            if (idx == `G1_CDB_LAST)
            begin
              cdb_ready_o <= 1'b0;
              state <= g1_pkg::ST_DECODE;
            end
          end
        end
        g1_pkg::ST_DECODE:
        begin
          idx <= 4'h0;
          if (!known || rsvd_bad || rel_bad || count > `G1_MAX_BLOCKS ||
              count == 16'h0000)
            state <= g1_pkg::ST_REPORT;
          else
            state <= g1_pkg::ST_EXEC;
        end
        g1_pkg::ST_EXEC:
        begin
          if (op_done_i)
            state <= g1_pkg::ST_REPORT;
        end
        g1_pkg::ST_REPORT:
        begin
          cdb_ready_o <= 1'b1;
          state <= g1_pkg::ST_GATHER;
        end
        default:
        begin
          cdb_ready_o <= 1'b1;
          state <= g1_pkg::ST_GATHER;
        end
      endcase
    end
  end

  // drive operation request, one pulse per accepted command with a nonzero count
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      op_valid_o <= 1'b0;
      op_kind_o <= g1_pkg::OPK_WRITE;
      op_lun_o <= 3'h0;
      op_lba_o <= 32'h0000_0000;
      op_count_o <= 9'h000;
      op_retry_o <= 1'b0;
      op_ecc_o <= 1'b0;
      end_lba <= 32'h0000_0000;
    end
    else
    begin
      op_valid_o <= 1'b0;
      if (state == g1_pkg::ST_DECODE)
      begin
        op_valid_o <= known && !rsvd_bad && !rel_bad && count != 16'h0000 &&
                      count <= `G1_MAX_BLOCKS;
        op_lun_o <= lun;
        op_lba_o <= start_lba;
        op_count_o <= count[8:0];
        end_lba <= start_lba + 32'(count[8:0]) - 32'h0000_0001;
        op_retry_o <= cdb[`G1_BYTE_CTRL][`G1_RETRY_BIT];
        op_ecc_o <= cdb[`G1_BYTE_CTRL][`G1_ECC_BIT];
        if (opc == `G1_OP_WRITE_EXT)
          op_kind_o <= g1_pkg::OPK_WRITE;
        else if (opc == `G1_OP_VERIFY)
          op_kind_o <= byte_compare ? g1_pkg::OPK_VERIFY_CMP
                                    : g1_pkg::OPK_VERIFY_ECC;
        else
          op_kind_o <= byte_compare ? g1_pkg::OPK_WRITE_VERIFY_CMP
                            : g1_pkg::OPK_WRITE_VERIFY_ECC;
      end
    end
  end

  // data phase: ready is predicted a cycle ahead so the fifo never overflows
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      bytes_left <= 25'h0;
      data_ready_o <= 1'b0;
    end
    else if (state == g1_pkg::ST_DECODE)
    begin
      bytes_left <= moves_data ? total : 25'h0;
      data_ready_o <= moves_data && total != 25'h0 && known && !rsvd_bad && !rel_bad &&
                      count != 16'h0000 && count <= `G1_MAX_BLOCKS;
    end
    else if (state == g1_pkg::ST_EXEC)
    begin
      bytes_left <= bytes_left - 25'(push);
      data_ready_o <= (bytes_left - 25'(push) != 25'h0) &&
                      ((LW+1)'(level) + (LW+1)'(push) < (LW+1)'(FIFO_DEPTH));
    end
    else
      data_ready_o <= 1'b0;
  end

  // bus released only once no initiator data is still owed
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      disconnect_o <= 1'b0;
    else
      disconnect_o <= disconnect_en_i && state == g1_pkg::ST_EXEC && !op_done_i &&
                      bytes_left == 25'h0;
  end

  // result of the command, latched until report
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cmd_good <= 1'b0;
      cmd_link <= 1'b0;
      cmd_flag <= 1'b0;
      sense_key_o <= `G1_SK_NONE;
    end
    else if (state == g1_pkg::ST_DECODE)
    begin
      cmd_link <= cdb[`G1_BYTE_CTRL][`G1_LINK_BIT];
      cmd_flag <= cdb[`G1_BYTE_CTRL][`G1_FLAG_BIT];
      cmd_good <= known && !rsvd_bad && !rel_bad && count <= `G1_MAX_BLOCKS;
      sense_key_o <= (known && !rsvd_bad && !rel_bad && count <= `G1_MAX_BLOCKS)
                     ? `G1_SK_NONE : `G1_SK_ILLEGAL;
    end
    else if (state == g1_pkg::ST_EXEC && op_done_i)
    begin
      cmd_good <= op_sense_i == `G1_SK_NONE;
      sense_key_o <= op_sense_i;
    end
  end

  // status for every command; link and flag act only after success
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      status_valid_o <= 1'b0;
      status_o <= `G1_ST_GOOD;
      link_next_o <= 1'b0;
      flag_irq_o <= 1'b0;
      in_chain <= 1'b0;
    end
    else
    begin
      status_valid_o <= state == g1_pkg::ST_REPORT;
      link_next_o <= state == g1_pkg::ST_REPORT && cmd_good && cmd_link;
      flag_irq_o <= state == g1_pkg::ST_REPORT && cmd_good && cmd_link && cmd_flag;
      if (state == g1_pkg::ST_REPORT)
      begin
        status_o <= !cmd_good ? `G1_ST_CHECK :
                    cmd_link ? `G1_ST_INTERMEDIATE : `G1_ST_GOOD;
        in_chain <= cmd_good && cmd_link;
      end
    end
  end
endmodule : g1_cmd_decoder
`default_nettype wire

// >>> g1_cmd_decoder_sva.sv
// concurrent checks on the decoder's top-level ports
`default_nettype none
module g1_cmd_decoder_sva #(
  parameter int FIFO_DEPTH = 8,
  parameter int LUNS = 8
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic disconnect_en_i,
  input wire logic cdb_ready_o,
  input wire logic data_ready_o,
  input wire logic drv_valid_o,
  input wire logic [7:0] drv_byte_o,
  input wire logic drv_ready_i,
  input wire logic op_valid_o,
  input wire g1_pkg::op_kind_t op_kind_o,
  input wire logic [8:0] op_count_o,
  input wire logic op_done_i,
  input wire logic disconnect_o,
  input wire logic status_valid_o,
  input wire logic [7:0] status_o,
  input wire logic [3:0] sense_key_o,
  input wire logic link_next_o,
  input wire logic flag_irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  // data phase opens together with the request unless ecc-only verify
  AST_DATA_OPENS: assert property (
    op_valid_o && op_kind_o != g1_pkg::OPK_VERIFY_ECC |-> data_ready_o)
    else $error("data phase did not open");
  AST_NO_DATA_ECC: assert property (data_ready_o |-> op_kind_o != g1_pkg::OPK_VERIFY_ECC)
    else $error("data taken on ecc-only verify");
  AST_COUNT_RANGE: assert property (
    op_valid_o |-> op_count_o != 9'h000 && op_count_o <= 9'h100)
    else $error("op count out of range");
  AST_OP_PULSE: assert property (op_valid_o |=> !op_valid_o)
    else $error("op request longer than one cycle");
  // decode takes a cycle, so nothing is answered right after byte 9
  AST_DECODE_GAP: assert property (
    $fell(cdb_ready_o) |-> !status_valid_o ##1 !status_valid_o)
    else $error("status too early after command");
  AST_REOPEN: assert property (status_valid_o |=> cdb_ready_o)
    else $error("command port not reopened");
  AST_LINK_GOOD: assert property (
    link_next_o |-> status_valid_o && status_o == 8'h10 && sense_key_o == 4'h0)
    else $error("link fetch without good status");
  AST_FLAG_LINK: assert property (flag_irq_o |-> link_next_o)
    else $error("interrupt request without link");
  AST_DISC_EN: assert property (
    $rose(disconnect_o) |-> $past(disconnect_en_i) && !data_ready_o)
    else $error("bus released while not allowed");
  AST_DISC_DROP: assert property (op_done_i && disconnect_o |=> !disconnect_o)
    else $error("bus not retaken after done");
  AST_DRV_HOLD: assert property (
    drv_valid_o && !drv_ready_i |=> drv_valid_o && $stable(drv_byte_o))
    else $error("drive byte changed while stalled");
endmodule : g1_cmd_decoder_sva
bind g1_cmd_decoder g1_cmd_decoder_sva #(.FIFO_DEPTH(FIFO_DEPTH), .LUNS(LUNS)) i_sva (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .disconnect_en_i(disconnect_en_i),
  .cdb_ready_o(cdb_ready_o), .data_ready_o(data_ready_o), .drv_valid_o(drv_valid_o),
  .drv_byte_o(drv_byte_o), .drv_ready_i(drv_ready_i), .op_valid_o(op_valid_o),
  .op_kind_o(op_kind_o), .op_count_o(op_count_o), .op_done_i(op_done_i),
  .disconnect_o(disconnect_o), .status_valid_o(status_valid_o), .status_o(status_o),
  .sense_key_o(sense_key_o), .link_next_o(link_next_o), .flag_irq_o(flag_irq_o));
`default_nettype wire

// >>> initiator_model.sv
// initiator side: offers command and data bytes on valid/ready
`default_nettype none
module initiator_model (
  input wire logic mclk_i,
  input wire logic cdb_ready_i,
  input wire logic data_ready_i,
  output logic cdb_valid_o,
  output logic [7:0] cdb_byte_o,
  output logic data_valid_o,
  output logic [7:0] data_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sent[$];
  initial
  begin
    cdb_valid_o = 1'b0;
    cdb_byte_o = 8'h00;
    data_valid_o = 1'b0;
    data_byte_o = 8'h00;
  end
  // ready is looked at on the falling edge, so the taking edge is never raced
  task automatic send_cdb(input logic [79:0] cdb);
    for (int i = 0; i < 10; i++)
    begin
      @(negedge mclk_i);
      cdb_valid_o = 1'b1;
      cdb_byte_o = (i == 6) ? 8'h00 : cdb[79-8*i -: 8];
      while (cdb_ready_i !== 1'b1) @(negedge mclk_i);
      @(posedge mclk_i);
    end
    @(negedge mclk_i);
    cdb_valid_o = 1'b0;
    cdb_byte_o = ~cdb_byte_o;
  endtask : send_cdb
  // released data line shows the inverse so stale bytes never look valid
  task automatic send_data(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge mclk_i);
      data_valid_o = 1'b1;
      data_byte_o = 8'($urandom);
      while (data_ready_i !== 1'b1) @(negedge mclk_i);
      @(posedge mclk_i);
      sent.push_back(data_byte_o);
    end
    @(negedge mclk_i);
    data_valid_o = 1'b0;
    data_byte_o = ~data_byte_o;
  endtask : send_data
endmodule : initiator_model
`default_nettype wire

// >>> test_scsi_group1_verify_write_decoder.sv
// self-checking bench for the group 1 command decoder
`default_nettype none
`define CHK(nm, ex, gt) begin n_tests++; if ((ex) !== (gt)) begin n_errors++; \
  $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module test_scsi_group1_verify_write_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, sys_rst_i, disc_en, cdb_valid, cdb_ready, data_valid, data_ready;
  logic drv_valid, drv_ready, op_valid, op_retry, op_ecc, op_done, disc, st_valid;
  logic link_next, flag_irq;
  logic [15:0] block_len;
  logic [7:0] cdb_byte, data_byte, drv_byte, status;
  logic [3:0] op_sense, sense_key;
  logic [2:0] op_lun;
  logic [31:0] op_lba;
  logic [8:0] op_count;
  g1_pkg::op_kind_t op_kind;
  int n_errors, n_tests;
  logic [7:0] got[$];
  logic [31:0] last_lba [8];
  logic has_lba [8];
  logic chain;
  g1_cmd_decoder i_dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .block_len_i(block_len),
    .disconnect_en_i(disc_en), .cdb_valid_i(cdb_valid), .cdb_byte_i(cdb_byte),
    .cdb_ready_o(cdb_ready), .data_valid_i(data_valid), .data_byte_i(data_byte),
    .data_ready_o(data_ready), .drv_valid_o(drv_valid), .drv_byte_o(drv_byte),
    .drv_ready_i(drv_ready), .op_valid_o(op_valid), .op_kind_o(op_kind), .op_lun_o(op_lun),
    .op_lba_o(op_lba), .op_count_o(op_count), .op_retry_o(op_retry), .op_ecc_o(op_ecc),
    .op_done_i(op_done), .op_sense_i(op_sense), .disconnect_o(disc),
    .status_valid_o(st_valid), .status_o(status), .sense_key_o(sense_key),
    .link_next_o(link_next), .flag_irq_o(flag_irq));
  initiator_model i_init (.mclk_i(mclk_i), .cdb_ready_i(cdb_ready), .data_ready_i(data_ready),
    .cdb_valid_o(cdb_valid), .cdb_byte_o(cdb_byte), .data_valid_o(data_valid),
    .data_byte_o(data_byte));
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  // drive side stalls at random so the fifo fills and refuses
  always @(negedge mclk_i) drv_ready = ($urandom_range(0, 3) == 0);
  always @(posedge mclk_i) if (drv_valid && drv_ready) got.push_back(drv_byte);
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic run_cmd(input string nm, input logic [7:0] opc, input logic [7:0] b1,
    input logic [31:0] lba, input logic [15:0] cnt, input logic [7:0] b9, input logic [3:0] sk);
    logic rej, has_op;
    logic [31:0] elba;
    logic [7:0] est;
    g1_pkg::op_kind_t kind;
    int n;
    block_len = 16'($urandom_range(1, 6));
    disc_en = 1'($urandom);
    rej = !(opc inside {8'h2f, 8'h2a, 8'h2e}) || (b1 & 8'h1c) != 0 || (b9 & 8'h3c) != 0;
    rej = rej || (opc == 8'h2a && b1[1]) || cnt > 16'h0100;
    rej = rej || (b1[0] && !(chain && has_lba[b1[7:5]]));
    elba = b1[0] ? last_lba[b1[7:5]] + lba : lba;
    kind = b1[1] ? g1_pkg::OPK_VERIFY_CMP : g1_pkg::OPK_VERIFY_ECC;
    if (opc == 8'h2a) kind = g1_pkg::OPK_WRITE;
    if (opc == 8'h2e) kind = b1[1] ? g1_pkg::OPK_WRITE_VERIFY_CMP : g1_pkg::OPK_WRITE_VERIFY_ECC;
    n = (kind == g1_pkg::OPK_VERIFY_ECC) ? 0 : cnt * block_len;
    has_op = !rej && cnt != 0;
    got.delete();
    i_init.sent.delete();
    i_init.send_cdb({opc, b1, lba, 8'h00, cnt, b9});
    for (int i = 0; i < 40 && op_valid !== 1'b1 && st_valid !== 1'b1; i++) @(negedge mclk_i);
    `CHK("op_valid", has_op, op_valid)
    if (has_op)
    begin
      `CHK("kind", kind, op_kind)
      `CHK("lun", b1[7:5], op_lun)
      `CHK("lba", elba, op_lba)
      `CHK("count", cnt[8:0], op_count)
      `CHK("retry_ecc", b9[7:6], {op_retry, op_ecc})
      i_init.send_data(n);
      for (int i = 0; i < 400 && got.size() < n; i++) @(negedge mclk_i);
      repeat (3) @(negedge mclk_i);
      `CHK("bytes", n, got.size())
      for (int i = 0; i < n && i < got.size(); i++) `CHK("byte", i_init.sent[i], got[i])
      `CHK("disconnect", disc_en, disc)
      op_done = 1'b1;
      op_sense = sk;
      @(negedge mclk_i);
      op_done = 1'b0;
      op_sense = 4'h0;
    end
    for (int i = 0; i < 20 && st_valid !== 1'b1; i++) @(negedge mclk_i);
    est = (rej || (has_op && sk != 4'h0)) ? 8'h02 : (b9[0] ? 8'h10 : 8'h00);
    `CHK("status_valid", 1'b1, st_valid)
    `CHK("status", est, status)
    `CHK("sense", rej ? 4'h5 : (has_op ? sk : 4'h0), sense_key)
    `CHK("link_next", est == 8'h10, link_next)
    `CHK("flag_irq", est == 8'h10 && b9[1], flag_irq)
    chain = (est == 8'h10);
    for (int l = 0; l < 8; l++) if (!chain) has_lba[l] = 1'b0;
    if (chain && has_op) has_lba[b1[7:5]] = 1'b1;
    if (chain && has_op) last_lba[b1[7:5]] = elba + 32'(cnt) - 32'h1;
    @(negedge mclk_i);
    $display("TEST %s done", nm);
  endtask : run_cmd
  initial
  begin
    #(4 * 60000);
    n_errors++;
    results();
  end
  initial
  begin
    {sys_rst_i, disc_en, drv_ready, op_done, op_sense, chain} = '0;
    sys_rst_i = 1'b1;
    block_len = 16'h0004;
    for (int l = 0; l < 8; l++) has_lba[l] = 1'b0;
    void'($urandom(32'h15fa));
    repeat (10) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    run_cmd("write_link_flag", 8'h2a, 8'h60, 32'h01020304, 16'h2, 8'hc3, 4'h0);
    run_cmd("verify_rel_cmp", 8'h2f, 8'h63, 32'hffffffff, 16'h1, 8'h01, 4'h0);
    run_cmd("wv_rel_fail", 8'h2e, 8'h61, 32'h2, 16'h1, 8'h00, 4'h3);
    run_cmd("rel_no_chain", 8'h2f, 8'h61, 32'h1, 16'h1, 8'h00, 4'h0);
    run_cmd("verify_256", 8'h2f, 8'ha0, 32'h1000, 16'h0100, 8'h40, 4'h0);
    run_cmd("count_257", 8'h2f, 8'h00, 32'h0, 16'h0101, 8'h00, 4'h0);
    run_cmd("count_zero", 8'h2a, 8'h00, 32'h5, 16'h0, 8'h00, 4'h0);
    run_cmd("bad_opcode", 8'h28, 8'h00, 32'h5, 16'h1, 8'h00, 4'h0);
    run_cmd("rsvd_flags", 8'h2f, 8'h04, 32'h5, 16'h1, 8'h00, 4'h0);
    run_cmd("cmp_on_write", 8'h2a, 8'h02, 32'h5, 16'h1, 8'h00, 4'h0);
    run_cmd("rsvd_ctrl", 8'h2e, 8'h00, 32'h5, 16'h1, 8'h20, 4'h0);
    run_cmd("flag_no_link", 8'h2e, 8'h02, 32'h7, 16'h1, 8'h02, 4'h0);
    for (int k = 0; k < 6; k++)
      run_cmd("random", (k % 3 == 0) ? 8'h2a : ((k % 3 == 1) ? 8'h2e : 8'h2f),
        {3'($urandom), 3'h0, (k % 3 != 0) && 1'($urandom), 1'b0}, $urandom,
        16'($urandom_range(1, 3)), {2'($urandom), 5'h0, 1'($urandom)}, 4'h0);
    results();
  end
endmodule : test_scsi_group1_verify_write_decoder
`default_nettype wire
